// [include/ptc_pkg.sv]
// Package with the register map, field layout and encodings of the 8-bit preload timer/counter.
package ptc_pkg;

  localparam int PTC_ADR_W = 12;
  localparam int PTC_DAT_W = 32;
  localparam int PTC_CNT_W = 8;

  // Register byte offsets; every register sits on data bits 7:0.
  localparam logic [PTC_ADR_W-1:0] PTC_IDX_CTRL = 12'h042;
  localparam logic [PTC_ADR_W-1:0] PTC_IDX_RELOAD = 12'h043;
  localparam logic [PTC_ADR_W-1:0] PTC_IDX_COUNT = 12'h044;
  localparam logic [PTC_ADR_W-1:0] PTC_IDX_DOUT = 12'h045;
  localparam logic [PTC_ADR_W-1:0] PTC_IDX_DIN = 12'h046;

  localparam logic [PTC_ADR_W-1:0] PTC_ADR_CTRL = PTC_IDX_CTRL;
  localparam logic [PTC_ADR_W-1:0] PTC_ADR_RELOAD = PTC_IDX_RELOAD;
  localparam logic [PTC_ADR_W-1:0] PTC_ADR_COUNT = PTC_IDX_COUNT;
  localparam logic [PTC_ADR_W-1:0] PTC_ADR_DOUT = PTC_IDX_DOUT;
  localparam logic [PTC_ADR_W-1:0] PTC_ADR_DIN = PTC_IDX_DIN;

  // Count clock source selection.
  localparam logic [1:0] PTC_SRC_MAIN = 2'h0;
  localparam logic [1:0] PTC_SRC_AUX = 2'h1;
  localparam logic [1:0] PTC_SRC_PIN = 2'h2;
  localparam logic [1:0] PTC_SRC_GATED = 2'h3;

  // Control register field positions.
  localparam int PTC_CTL_SEL_LSB = 0;
  localparam int PTC_CTL_EN_BIT = 2;
  localparam int PTC_CTL_STEN_BIT = 3;
  localparam int PTC_CTL_STFLG_BIT = 4;
  localparam int PTC_CTL_CYFLG_BIT = 5;

  // Control register image, MSB first.
  typedef struct packed {
    logic [1:0] rsvd;
    logic carry_seen;
    logic start_seen;
    logic start_en;
    logic cnt_en;
    logic [1:0] clk_sel;
  } ptc_ctrl_s;

  // Bus request bundle.
  typedef struct packed {
    logic we;
    logic [PTC_ADR_W-1:0] adr;
    logic [PTC_DAT_W-1:0] dat;
    logic sel0;
  } ptc_req_s;

  localparam ptc_ctrl_s PTC_CTRL_RST = '{default: 1'b0};
  localparam logic [PTC_CNT_W-1:0] PTC_CNT_RST = 8'h00;
  localparam logic [PTC_CNT_W-1:0] PTC_CNT_MAX = 8'hff;
  localparam logic [PTC_CNT_W-1:0] PTC_CNT_ONE = 8'h01;

endpackage : ptc_pkg

// [logic/ptc_edge_det.sv]
// Rising and falling edge detector for a level that is synchronous to the clock.
`timescale 1ns/100ps

module ptc_edge_det (
  input wire logic ref_clk_i, // Block clock.
  input wire logic rst_n_i,   // Asynchronous reset, active low.
  input wire logic sig_i,     // Level to watch.
  output logic rise_o,        // One-cycle pulse on a low to high change.
  output logic fall_o         // One-cycle pulse on a high to low change.
);

  logic prev;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev <= 1'b0;
    end else begin
      prev <= sig_i;
    end
  end

  assign rise_o = sig_i & ~prev;
  assign fall_o = ~sig_i & prev;

endmodule : ptc_edge_det

// [logic/ptc_timer.sv]
// Eight-bit preload timer/counter with a classic Wishbone register slave.
`timescale 1ns/100ps

// Notes on behaviour
// - An 8-bit up-only counter paired with a separate 8-bit preload register.
// - Two control bits choose main clock, aux clock, pin, or gated clock.
// - Gated source is main clock ANDed with the external count pin.
// - A write to the count register with wb_sel_i[0] set loads the preload value instead.
// - Preload may be rewritten right after a load without disturbing the count.
// - Preload register is readable and writable, reads return the stored value.
// - With enable high, count rises by one per rising edge of source.
// - Input and output data latches both update on counter carry-out.
// - Edge detection on the serial input finds an asynchronous start bit.
// - Control, preload and count registers sit at indices 42h, 43h, 44h.
// - Internal load and enable inputs govern the counter.
module ptc_timer (
  input wire logic ref_clk_i,                               // Block clock, 20 MHz.
  input wire logic rst_n_i,                                 // Asynchronous reset, active low.
  input wire logic wb_cyc_i,                                // Wishbone cycle.
  input wire logic wb_stb_i,                                // Wishbone strobe.
  input wire logic wb_we_i,                                 // Wishbone write enable.
  input wire logic [ptc_pkg::PTC_ADR_W-1:0] wb_adr_i,       // Wishbone byte address.
  input wire logic [3:0] wb_sel_i,                          // Wishbone byte selects.
  input wire logic [ptc_pkg::PTC_DAT_W-1:0] wb_dat_i,       // Wishbone write data.
  output logic [ptc_pkg::PTC_DAT_W-1:0] wb_dat_o,           // Wishbone read data.
  output logic wb_ack_o,                                    // Wishbone acknowledge.
  input wire logic main_clk_i,                              // Main clock level, sampled.
  input wire logic aux_clk_i,                               // Auxiliary clock level, sampled.
  input wire logic ext_count_pin_i,                         // External count and serial pin.
  input wire logic [ptc_pkg::PTC_CNT_W-1:0] data_in_i,      // Parallel data to input latch.
  output logic [ptc_pkg::PTC_CNT_W-1:0] data_out_o,         // Output data latch.
  output logic carry_o,                                     // Carry-out pulse.
  output logic start_o                                      // Start edge pulse.
);

  localparam int CW = ptc_pkg::PTC_CNT_W;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave.

  ptc_pkg::ptc_req_s req;
  ptc_pkg::ptc_ctrl_s ctrl;
  logic [1:0] clk_sel;
  logic cnt_en;
  logic start_en;
  logic start_seen;
  logic carry_seen;
  logic [CW-1:0] reload;
  logic [CW-1:0] count;
  logic [CW-1:0] dout_stage;
  logic [CW-1:0] din_latch;
  logic bus_req;
  logic bus_wr;
  logic [ptc_pkg::PTC_DAT_W-1:0] next_rdata;

  // Returns one when the byte address hits the given register.
  function automatic logic ptc_hit(input logic [ptc_pkg::PTC_ADR_W-1:0] adr,
                                   input logic [ptc_pkg::PTC_ADR_W-1:0] reg_adr);
    ptc_hit = (adr == reg_adr);
  endfunction : ptc_hit

  assign req = '{we: wb_we_i, adr: wb_adr_i, dat: wb_dat_i, sel0: wb_sel_i[0]};
  assign bus_req = wb_cyc_i & wb_stb_i;
  // Writes take effect on the edge at which the master sees ack.
  assign bus_wr = bus_req & wb_ack_o & req.we & req.sel0;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
    end
  end

  // Unmapped addresses are acknowledged and read as zero.
  always_comb begin
    next_rdata = '0;
    if (ptc_hit(req.adr, ptc_pkg::PTC_ADR_CTRL)) begin
      next_rdata[CW-1:0] = ctrl;
    end else if (ptc_hit(req.adr, ptc_pkg::PTC_ADR_RELOAD)) begin
      next_rdata[CW-1:0] = reload;
    end else if (ptc_hit(req.adr, ptc_pkg::PTC_ADR_COUNT)) begin
      next_rdata[CW-1:0] = count;
    end else if (ptc_hit(req.adr, ptc_pkg::PTC_ADR_DOUT)) begin
      next_rdata[CW-1:0] = dout_stage;
    end else if (ptc_hit(req.adr, ptc_pkg::PTC_ADR_DIN)) begin
      next_rdata[CW-1:0] = din_latch;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wb_dat_o <= '0;
    end else if (bus_req & ~wb_ack_o) begin
      wb_dat_o <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control, preload and output staging registers.

  logic wr_ctrl;
  logic wr_reload;
  logic wr_count;
  logic wr_dout;
  logic start_evt;
  logic carry_evt;

  assign wr_ctrl = bus_wr & ptc_hit(req.adr, ptc_pkg::PTC_ADR_CTRL);
  assign wr_reload = bus_wr & ptc_hit(req.adr, ptc_pkg::PTC_ADR_RELOAD);
  assign wr_count = bus_wr & ptc_hit(req.adr, ptc_pkg::PTC_ADR_COUNT);
  assign wr_dout = bus_wr & ptc_hit(req.adr, ptc_pkg::PTC_ADR_DOUT);

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clk_sel <= ptc_pkg::PTC_CTRL_RST.clk_sel;
      cnt_en <= ptc_pkg::PTC_CTRL_RST.cnt_en;
      start_en <= ptc_pkg::PTC_CTRL_RST.start_en;
    end else if (wr_ctrl) begin
      clk_sel <= req.dat[ptc_pkg::PTC_CTL_SEL_LSB +: 2];
      cnt_en <= req.dat[ptc_pkg::PTC_CTL_EN_BIT];
      start_en <= req.dat[ptc_pkg::PTC_CTL_STEN_BIT];
    end
  end

  // The two flags have one process each and the writable fields share one; the reserved bits read as zero.
  assign ctrl = '{rsvd: 2'h0, carry_seen: carry_seen, start_seen: start_seen,
                  start_en: start_en, cnt_en: cnt_en, clk_sel: clk_sel};

  // Sticky flags; writing one clears, and a new event in that cycle wins.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      start_seen <= ptc_pkg::PTC_CTRL_RST.start_seen;
    end else if (start_evt) begin
      start_seen <= 1'b1;
    end else if (wr_ctrl & req.dat[ptc_pkg::PTC_CTL_STFLG_BIT]) begin
      start_seen <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      carry_seen <= ptc_pkg::PTC_CTRL_RST.carry_seen;
    end else if (carry_evt) begin
      carry_seen <= 1'b1;
    end else if (wr_ctrl & req.dat[ptc_pkg::PTC_CTL_CYFLG_BIT]) begin
      carry_seen <= 1'b0;
    end
  end

  // The preload is a buffer of its own, so rewriting it never touches the count.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reload <= ptc_pkg::PTC_CNT_RST;
    end else if (wr_reload) begin
      reload <= req.dat[CW-1:0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dout_stage <= ptc_pkg::PTC_CNT_RST;
    end else if (wr_dout) begin
      dout_stage <= req.dat[CW-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Count clock selection and edge detection.

  logic src_level;
  logic src_rise;
  logic ser_fall;

  // A change of selection may itself look like one source edge.
  always_comb begin
    case (ctrl.clk_sel)
      ptc_pkg::PTC_SRC_MAIN: src_level = main_clk_i;
      ptc_pkg::PTC_SRC_AUX: src_level = aux_clk_i;
      ptc_pkg::PTC_SRC_PIN: src_level = ext_count_pin_i;
      ptc_pkg::PTC_SRC_GATED: src_level = main_clk_i & ext_count_pin_i;
      default: src_level = 1'b0;
    endcase
  end

  ptc_edge_det u_src_edge (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .sig_i(src_level),
    .rise_o(src_rise),
    .fall_o()
  );

  // An idle-high serial line falling low marks a start bit.
  ptc_edge_det u_ser_edge (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .sig_i(ext_count_pin_i),
    .rise_o(),
    .fall_o(ser_fall)
  );

  assign start_evt = ser_fall & ctrl.start_en;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      start_o <= 1'b0;
    end else begin
      start_o <= start_evt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Counter.

  logic cnt_load;
  logic cnt_enable;
  logic cnt_step;
  logic [CW-1:0] next_count;

  assign cnt_load = wr_count;
  assign cnt_enable = ctrl.cnt_en;
  assign cnt_step = cnt_enable & src_rise & ~cnt_load;
  assign carry_evt = cnt_step & (count == ptc_pkg::PTC_CNT_MAX);

  always_comb begin
    next_count = count;
    if (cnt_load) begin
      next_count = reload;
    end else if (cnt_step) begin
      next_count = count + ptc_pkg::PTC_CNT_ONE;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= ptc_pkg::PTC_CNT_RST;
    end else begin
      count <= next_count;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      carry_o <= 1'b0;
    end else begin
      carry_o <= carry_evt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Data latches clocked by the carry-out.

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      din_latch <= ptc_pkg::PTC_CNT_RST;
    end else if (carry_evt) begin
      din_latch <= data_in_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_out_o <= ptc_pkg::PTC_CNT_RST;
    end else if (carry_evt) begin
      data_out_o <= dout_stage;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");

  count_load_a: assert property (wr_count |=> count == $past(reload))
    else $error("count write did not load the preload value");

  reload_keep_a: assert property (wr_reload && !src_rise |=> $stable(count))
    else $error("preload write disturbed the count");

  count_hold_a: assert property (!cnt_enable && !cnt_load |=> $stable(count))
    else $error("count moved while disabled");

  count_step_a: assert property (
    cnt_enable && src_rise && !cnt_load |=> count == 8'($past(count) + 8'h01))
    else $error("count did not step by one");

  carry_wrap_a: assert property (carry_o |-> count == 8'h00 && $past(count) == 8'hff)
    else $error("carry without wrap");

  latch_carry_a: assert property (
    carry_o |-> din_latch == $past(data_in_i) && data_out_o == $past(dout_stage))
    else $error("data latches missed the carry");

  gated_src_a: assert property (
    ctrl.clk_sel == ptc_pkg::PTC_SRC_GATED && !(main_clk_i && ext_count_pin_i) && !cnt_load |=>
    $stable(count))
    else $error("gated source stepped while its gate was closed");

  start_flag_a: assert property (
    ctrl.start_en && $fell(ext_count_pin_i) |=> ctrl.start_seen && start_o)
    else $error("start edge not flagged");

  reload_read_a: assert property (
    bus_req && !wb_ack_o && !req.we && req.adr == ptc_pkg::PTC_ADR_RELOAD |=>
    wb_ack_o && wb_dat_o[7:0] == reload)
    else $error("preload read mismatch");

  ack_timing_a: assert property (bus_req && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged in the next cycle");

  count_up_a: assert property (
    !cnt_load |=> count == $past(count) || count == 8'($past(count) + 8'h01))
    else $error("count moved other than up by one");

  aux_src_a: assert property (
    ctrl.clk_sel == ptc_pkg::PTC_SRC_AUX && !aux_clk_i && !cnt_load |=> $stable(count))
    else $error("aux source stepped while low");

  pin_src_a: assert property (
    ctrl.clk_sel == ptc_pkg::PTC_SRC_PIN && !ext_count_pin_i && !cnt_load |=> $stable(count))
    else $error("pin source stepped while low");

  carry_once_a: assert property (carry_o |=> !carry_o)
    else $error("carry longer than one cycle");

  carry_flag_a: assert property (carry_o |-> ctrl.carry_seen)
    else $error("carry flag not set on carry");

  start_gate_a: assert property (start_o |-> $past(ctrl.start_en))
    else $error("start pulse while start detection off");

  load_cov: cover property (wr_count ##1 wr_reload);
  wrap_cov: cover property (carry_o);
  start_cov: cover property (start_o);
  gated_cov: cover property (ctrl.clk_sel == ptc_pkg::PTC_SRC_GATED && cnt_step);
  aux_cov: cover property (ctrl.clk_sel == ptc_pkg::PTC_SRC_AUX && cnt_step);

endmodule : ptc_timer

// [sim/ptc_pin_model.sv]
// Behavioural model of the external count and serial pin.
`timescale 1ns/100ps

module ptc_pin_model (
  input wire logic ref_clk_i, // Block clock.
  output logic pin_o          // Driven pin level.
);
  initial pin_o = 1'b0;

  // Called just after a rising edge; callers space edges at least one cycle apart.
  task automatic set(input logic lvl);
    pin_o <= lvl;
  endtask : set
endmodule : ptc_pin_model

// [sim/tb_top.sv]
// Self-checking testbench of the preload timer/counter.
`timescale 1ns/100ps

module tb_top;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, main_clk = 1'b0, aux_clk = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, dat_o;
  logic [7:0] din = 8'h00, dout;
  logic ack, pin, carry, start;
  int fail_count = 0, tests_run = 0;
  int cnt_m = 0, pl_m = 0, stg_m = 0, din_m = 0, dout_m = 0, ctl_m = 0, cy_m = 0;
  logic [31:0] q;
  logic [11:0] v_a[5] = '{ptc_pkg::PTC_ADR_CTRL, ptc_pkg::PTC_ADR_RELOAD,
    ptc_pkg::PTC_ADR_COUNT, ptc_pkg::PTC_ADR_DOUT, ptc_pkg::PTC_ADR_DIN};

  always #25 ref_clk_i = ~ref_clk_i;

  ptc_pin_model ptc_pin_model_inst (.ref_clk_i(ref_clk_i), .pin_o(pin));

  ptc_timer ptc_timer_inst (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .main_clk_i(main_clk), .aux_clk_i(aux_clk), .ext_count_pin_i(pin), .data_in_i(din),
    .data_out_o(dout), .carry_o(carry), .start_o(start));

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // One classic Wishbone cycle; the request holds until ack is sampled high.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= {24'h0, d}; sel <= 4'hf;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail_count++;
      stop_test();
    end
    q = dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
    case (a)
      ptc_pkg::PTC_ADR_RELOAD: pl_m = d;
      ptc_pkg::PTC_ADR_COUNT: cnt_m = pl_m;
      ptc_pkg::PTC_ADR_DOUT: stg_m = d;
      ptc_pkg::PTC_ADR_CTRL: begin
        ctl_m = (d & 8'h0f) | (ctl_m & 8'h10 & ~d);
        if (d[5]) cy_m = 0;
      end
      default: ;
    endcase
  endtask : wr

  task automatic rd(input string name, input logic [11:0] a, input int exp);
    xfer(1'b0, a, 8'h00);
    chk(name, exp, q);
  endtask : rd

  task automatic set_src(input int s, input logic lvl);
    if (s == 0) main_clk <= lvl;
    if (s == 1) aux_clk <= lvl;
    if (s == 2) ptc_pin_model_inst.set(lvl);
  endtask : set_src

  // One rising edge of a source, three cycles long, with the model stepped alongside.
  task automatic step(input int s);
    int hit, cy;
    cy = 0;
    @(posedge ref_clk_i);
    // The pin is read only here, once a level change made by the caller has settled.
    hit = ((ctl_m & 3) == s) || ((ctl_m & 3) == 3 && s == 0 && pin === 1'b1);
    set_src(s, 1'b1);
    din <= 8'($urandom);
    @(posedge ref_clk_i);
    set_src(s, 1'b0);
    if (ctl_m[2] && hit) begin
      cnt_m = (cnt_m + 1) % 256;
      if (cnt_m == 0) begin
        cy = 1; cy_m = 1; dout_m = stg_m; din_m = din;
      end
    end
    @(posedge ref_clk_i);
    chk("carry", cy, carry);
    chk("data_out", dout_m, dout);
  endtask : step

  initial begin
    #1000000;
    fail_count++;
    stop_test();
  end

  initial begin
    int v;
    void'($urandom(32'he1cb));
    repeat (6) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    foreach (v_a[i]) rd("reset", v_a[i], 0);
    wr(12'h200, 8'h77);
    rd("unmapped", 12'h200, 0);
    v = $urandom_range(1, 254);
    wr(ptc_pkg::PTC_ADR_RELOAD, 8'(v));
    rd("reload", ptc_pkg::PTC_ADR_RELOAD, v);
    wr(ptc_pkg::PTC_ADR_COUNT, 8'(v ^ 8'h5a));
    wr(ptc_pkg::PTC_ADR_RELOAD, 8'(v + 1));
    rd("count", ptc_pkg::PTC_ADR_COUNT, cnt_m);
    rd("reload", ptc_pkg::PTC_ADR_RELOAD, pl_m);
    for (int s = 0; s < 3; s++) begin
      wr(ptc_pkg::PTC_ADR_CTRL, 8'(4 + s));
      wr(ptc_pkg::PTC_ADR_COUNT, 8'h00);
      repeat (3) step(s);
      step((s + 1) % 3);
      rd("count", ptc_pkg::PTC_ADR_COUNT, cnt_m);
    end
    wr(ptc_pkg::PTC_ADR_CTRL, 8'h00);
    repeat (2) step(0);
    rd("count held", ptc_pkg::PTC_ADR_COUNT, cnt_m);
    ptc_pin_model_inst.set(1'b1);
    wr(ptc_pkg::PTC_ADR_CTRL, 8'h07);
    repeat (2) step(0);
    ptc_pin_model_inst.set(1'b0);
    repeat (2) step(0);
    rd("gated", ptc_pkg::PTC_ADR_COUNT, cnt_m);
    wr(ptc_pkg::PTC_ADR_DOUT, 8'($urandom));
    wr(ptc_pkg::PTC_ADR_RELOAD, 8'hfe);
    wr(ptc_pkg::PTC_ADR_CTRL, 8'h04);
    wr(ptc_pkg::PTC_ADR_COUNT, 8'h00);
    repeat (3) step(0);
    rd("din latch", ptc_pkg::PTC_ADR_DIN, din_m);
    rd("count wrap", ptc_pkg::PTC_ADR_COUNT, cnt_m);
    rd("ctrl", ptc_pkg::PTC_ADR_CTRL, ctl_m | (cy_m << 5));
    wr(ptc_pkg::PTC_ADR_CTRL, 8'h20);
    ptc_pin_model_inst.set(1'b1);
    wr(ptc_pkg::PTC_ADR_CTRL, 8'h08);
    @(posedge ref_clk_i);
    ptc_pin_model_inst.set(1'b0);
    v = 0;
    for (int i = 0; i < 4 && v == 0; i++) begin
      @(posedge ref_clk_i);
      v = (start === 1'b1);
    end
    chk("start", 1, v);
    @(posedge ref_clk_i);
    chk("start end", 0, start);
    rd("ctrl start", ptc_pkg::PTC_ADR_CTRL, 8'h18);
    stop_test();
  end

endmodule : tb_top
